// ---- core/oisp_top.sv ----
`timescale 1ns/1ps

// Overview of operation
// - Serializer input tracks channel states while chip select and freeze strobe are high.
// - Falling edge of freeze strobe or chip select freezes the serializer input.
// - Host drives chip select low to capture states and open an access.
// - Serial data input is sampled on every rising serial clock edge.
// - Serial data output changes on every falling serial clock edge.
// - Serial data output is released while chip select is high.
// - Fault pin pulled low while any fault flag is set.
// - Ready pin asserted only while both supplies are above lockout.
// - Check-code strap high adds check byte on output and checks input.
// - Chain strap high selects daisy-chain mode, low selects addressable mode.
// - Two strap pins give the chip address, bit 0 and bit 1.
// - Select bit 0: channels 1 to 3 are high-side open-drain LED anodes.
// - Select bit 0: channels 4 to 6 are low-side open-drain LED cathodes.
// - Select bit 1: all six outputs are push-pull logic outputs.
// - All eight channel states are captured at one instant.
module oisp_top (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // SPI pins
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic SDO_OE_N_O,
    // Freeze strobe and channel states
    input wire logic FREEZE_N_I,
    input wire logic [oisp_pkg::CH_NUM-1:0] CH_STATE_I,
    // Straps
    input wire logic CHECK_CODE_STRAP_I,
    input wire logic CHAIN_EN_STRAP_I,
    input wire logic CHIP_ADDR_BIT0_I,
    input wire logic CHIP_ADDR_BIT1_I,
    // Supply monitors
    input wire logic VA_ABOVE_UVLO_I,
    input wire logic VL_ABOVE_UVLO_I,
    // Fault flags from the fault registers
    input wire logic [oisp_pkg::FAULT_W-1:0] FAULT_FLAGS_I,
    // LED / logic outputs
    input wire logic OUTPUT_SELECT_BIT_I,
    input wire logic [oisp_pkg::LED_NUM-1:0] LED_ON_I,
    output logic [oisp_pkg::LED_NUM-1:0] LED_OUT_O,
    output logic [oisp_pkg::LED_NUM-1:0] LED_OE_N_O,
    // Status pins
    output logic FAULT_N_O,
    output logic FAULT_OE_N_O,
    output logic READY_N_O,
    output logic READY_OE_N_O,
    // Received byte stream
    output logic RX_VALID_O,
    input wire logic RX_READY_I,
    output logic [oisp_pkg::BYTE_W-1:0] RX_DATA_O,
    output logic RX_OVERRUN_O,
    output logic CRC_ERR_O,
    output logic [oisp_pkg::CH_NUM-1:0] FROZEN_STATE_O
);
    import oisp_pkg::*;

    logic [1:0] hi_s;
    logic [5:0] lo_s;
    logic [CH_NUM-1:0] ch_s;
    logic [1:0] sup_s;
    logic cs_s;
    logic freeze_s;
    logic sclk_s;
    logic sdi_s;
    logic crc_en;
    logic chain_en;
    logic [1:0] chip_addr;

    // Pulled-high pins reset high, pulled-low pins reset low
    oisp_sync #(.W(2), .RST_VAL(PULL_UP_VAL)) u_sync_hi (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .d_i({CS_N_I, FREEZE_N_I}),
        .q_o(hi_s)
    );
    oisp_sync #(.W(6), .RST_VAL(PULL_DOWN_VAL)) u_sync_lo (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .d_i({SCLK_I, SDI_I, CHECK_CODE_STRAP_I, CHAIN_EN_STRAP_I,
              CHIP_ADDR_BIT1_I, CHIP_ADDR_BIT0_I}),
        .q_o(lo_s)
    );
    oisp_sync #(.W(CH_NUM), .RST_VAL(PULL_DOWN_VAL)) u_sync_ch (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .d_i(CH_STATE_I),
        .q_o(ch_s)
    );
    oisp_sync #(.W(2), .RST_VAL(PULL_DOWN_VAL)) u_sync_sup (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .d_i({VA_ABOVE_UVLO_I, VL_ABOVE_UVLO_I}),
        .q_o(sup_s)
    );

    assign cs_s = hi_s[1];
    assign freeze_s = hi_s[0];
    assign sclk_s = lo_s[5];
    assign sdi_s = lo_s[4];
    assign crc_en = lo_s[3];
    assign chain_en = lo_s[2];
    assign chip_addr = lo_s[1:0];

    oisp_phase_e phase_r, phase_nxt;
    logic [CH_NUM-1:0] frozen_r, frozen_nxt;
    logic sclk_d_r, sclk_d_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] rx_sr_r, rx_sr_nxt;
    logic [7:0] tx_sr_r, tx_sr_nxt;
    logic [7:0] tx_next_r, tx_next_nxt;
    logic [7:0] tx_crc_r, tx_crc_nxt;
    logic [7:0] hold_r, hold_nxt;
    logic first_r, first_nxt;
    logic addr_ok_r, addr_ok_nxt;
    logic push_r, push_nxt;
    logic [7:0] push_data_r, push_data_nxt;
    logic crc_err_r, crc_err_nxt;
    logic overrun_r, overrun_nxt;
    logic sdo_r, sdo_nxt;
    logic sdo_oe_n_r, sdo_oe_n_nxt;

    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] rx_byte;
    logic byte_done;
    logic deliver;
    logic [7:0] deliver_data;
    logic fifo_wr_ready;

    assign sclk_rise = sclk_s && !sclk_d_r;
    assign sclk_fall = !sclk_s && sclk_d_r;
    assign rx_byte = {rx_sr_r[6:0], sdi_s};
    assign byte_done = sclk_rise && (bit_cnt_r == BIT_LAST) && (phase_r != PH_IDLE);

    always_comb begin
        phase_nxt = phase_r;
        frozen_nxt = frozen_r;
        sclk_d_nxt = sclk_s;
        bit_cnt_nxt = bit_cnt_r;
        rx_sr_nxt = rx_sr_r;
        tx_sr_nxt = tx_sr_r;
        tx_next_nxt = tx_next_r;
        tx_crc_nxt = tx_crc_r;
        hold_nxt = hold_r;
        first_nxt = first_r;
        addr_ok_nxt = addr_ok_r;
        push_nxt = 1'b0;
        push_data_nxt = push_data_r;
        crc_err_nxt = 1'b0;
        overrun_nxt = push_r && !fifo_wr_ready;
        deliver = 1'b0;
        deliver_data = rx_byte;

        // Transparent while both high; any fall holds all bits at once
        if (cs_s && freeze_s) begin
            frozen_nxt = ch_s;
        end

        if (cs_s) begin
            // Partial byte is dropped when select rises mid-byte
            phase_nxt = PH_IDLE;
        end else if (phase_r == PH_IDLE) begin
            // Frame opens with the states held before the fall
            phase_nxt = PH_DATA;
            bit_cnt_nxt = BIT_CNT_RST;
            tx_sr_nxt = frozen_r;
            tx_crc_nxt = oisp_crc8(frozen_r);
            first_nxt = 1'b1;
            addr_ok_nxt = 1'b0;
        end else begin
            if (sclk_rise) begin
                rx_sr_nxt = rx_byte;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
            end
            if (byte_done) begin
                if (phase_r == PH_DATA && crc_en) begin
                    hold_nxt = rx_byte;
                    phase_nxt = PH_CHECK;
                    tx_next_nxt = tx_crc_r;
                end else begin
                    if (phase_r == PH_CHECK) begin
                        phase_nxt = PH_DATA;
                        deliver_data = hold_r;
                        deliver = (rx_byte == oisp_crc8(hold_r));
                        crc_err_nxt = !deliver;
                    end else begin
                        deliver = 1'b1;
                    end
                    // Chain mode passes the upstream byte along
                    tx_next_nxt = chain_en ? rx_byte : frozen_r;
                    tx_crc_nxt = oisp_crc8(tx_next_nxt);
                end
            end
            if (sclk_fall) begin
                if (bit_cnt_r == BIT_CNT_RST) begin
                    tx_sr_nxt = tx_next_r;
                end else begin
                    tx_sr_nxt = {tx_sr_r[6:0], 1'b0};
                end
            end
        end

        if (deliver) begin
            if (first_r) begin
                first_nxt = 1'b0;
                addr_ok_nxt = deliver_data[ADDR_MSB:ADDR_LSB] == chip_addr;
            end
            if (chain_en || (first_r ? (deliver_data[ADDR_MSB:ADDR_LSB] == chip_addr)
                                     : addr_ok_r)) begin
                push_nxt = 1'b1;
                push_data_nxt = deliver_data;
            end
        end

        sdo_nxt = tx_sr_nxt[7];
        sdo_oe_n_nxt = (phase_nxt == PH_IDLE);
    end

    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            phase_r <= PH_IDLE;
            frozen_r <= BYTE_RST;
            sclk_d_r <= PULL_DOWN_VAL;
            bit_cnt_r <= BIT_CNT_RST;
            rx_sr_r <= BYTE_RST;
            tx_sr_r <= BYTE_RST;
            tx_next_r <= BYTE_RST;
            tx_crc_r <= BYTE_RST;
            hold_r <= BYTE_RST;
            first_r <= 1'b0;
            addr_ok_r <= 1'b0;
            push_r <= 1'b0;
            push_data_r <= BYTE_RST;
            crc_err_r <= 1'b0;
            overrun_r <= 1'b0;
            sdo_r <= 1'b0;
            sdo_oe_n_r <= 1'b1;
        end else begin
            phase_r <= phase_nxt;
            frozen_r <= frozen_nxt;
            sclk_d_r <= sclk_d_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            rx_sr_r <= rx_sr_nxt;
            tx_sr_r <= tx_sr_nxt;
            tx_next_r <= tx_next_nxt;
            tx_crc_r <= tx_crc_nxt;
            hold_r <= hold_nxt;
            first_r <= first_nxt;
            addr_ok_r <= addr_ok_nxt;
            push_r <= push_nxt;
            push_data_r <= push_data_nxt;
            crc_err_r <= crc_err_nxt;
            overrun_r <= overrun_nxt;
            sdo_r <= sdo_nxt;
            sdo_oe_n_r <= sdo_oe_n_nxt;
        end
    end

    // SPI cannot be stalled, so a full buffer drops the byte and flags it
    oisp_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .wr_valid_i(push_r),
        .wr_ready_o(fifo_wr_ready),
        .wr_data_i(push_data_r),
        .rd_valid_o(RX_VALID_O),
        .rd_ready_i(RX_READY_I),
        .rd_data_o(RX_DATA_O)
    );

    // Pin drivers
    logic fault_oe_n_r, fault_oe_n_nxt;
    logic ready_oe_n_r, ready_oe_n_nxt;
    logic [LED_NUM-1:0] led_out_r, led_out_nxt;
    logic [LED_NUM-1:0] led_oe_n_r, led_oe_n_nxt;

    always_comb begin
        fault_oe_n_nxt = !(|FAULT_FLAGS_I);
        // High-side: drive high until both supplies are good
        ready_oe_n_nxt = sup_s[1] && sup_s[0];
    end

    generate
        for (genvar i = 0; i < LED_NUM; i++) begin : g_led
            always_comb begin
                if (OUTPUT_SELECT_BIT_I) begin
                    led_out_nxt[i] = LED_ON_I[i];
                    led_oe_n_nxt[i] = 1'b0;
                end else if (i < HI_SIDE_NUM) begin
                    led_out_nxt[i] = 1'b1;
                    led_oe_n_nxt[i] = !LED_ON_I[i];
                end else begin
                    led_out_nxt[i] = 1'b0;
                    led_oe_n_nxt[i] = !LED_ON_I[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            fault_oe_n_r <= 1'b1;
            ready_oe_n_r <= 1'b0;
            led_out_r <= '0;
            led_oe_n_r <= '1;
        end else begin
            fault_oe_n_r <= fault_oe_n_nxt;
            ready_oe_n_r <= ready_oe_n_nxt;
            led_out_r <= led_out_nxt;
            led_oe_n_r <= led_oe_n_nxt;
        end
    end

    assign SDO_O = sdo_r;
    assign SDO_OE_N_O = sdo_oe_n_r;
    assign FAULT_N_O = 1'b0;
    assign FAULT_OE_N_O = fault_oe_n_r;
    assign READY_N_O = 1'b1;
    assign READY_OE_N_O = ready_oe_n_r;
    assign LED_OUT_O = led_out_r;
    assign LED_OE_N_O = led_oe_n_r;
    assign RX_OVERRUN_O = overrun_r;
    assign CRC_ERR_O = crc_err_r;
    assign FROZEN_STATE_O = frozen_r;
endmodule

// ---- pkg/oisp_pkg.sv ----
package oisp_pkg;
    // Channel and byte geometry
    localparam int CH_NUM = 8;
    localparam int LED_NUM = 6;
    localparam int HI_SIDE_NUM = 3;
    localparam int BYTE_W = 8;
    localparam int FAULT_W = 16;
    localparam int FIFO_DEPTH = 8;
    // Address field of the first received byte
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 6;
    // Check code
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // Reset values standing in for the weak pin pulls, then bit counter and byte constants
    localparam logic PULL_UP_VAL = 1'b1;
    localparam logic PULL_DOWN_VAL = 1'b0;
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        PH_IDLE  = 3'b001,
        PH_DATA  = 3'b010,
        PH_CHECK = 3'b100
    } oisp_phase_e;

    function automatic logic [7:0] oisp_crc8(input logic [7:0] d);
        logic [7:0] c;
        c = CRC_INIT ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction
endpackage

// ---- core/oisp_sync.sv ----
`timescale 1ns/1ps
module oisp_sync #(
    parameter int W = 1,
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    initial begin
        if (W < 1) $error("oisp_sync: W must be at least 1");
    end

    always_comb begin
        meta_nxt = d_i;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= {W{RST_VAL}};
            q_r <= {W{RST_VAL}};
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule

// ---- core/oisp_fifo.sv ----
`timescale 1ns/1ps
module oisp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [W-1:0] wr_data_i,
    // Drain side
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [W-1:0] rd_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] wr_ptr_nxt;
    logic [AW:0] rd_ptr_r;
    logic [AW:0] rd_ptr_nxt;
    logic full;
    logic empty;
    logic do_wr;
    logic do_rd;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("oisp_fifo: DEPTH must be a power of two >= 2");
        if (W < 1) $error("oisp_fifo: W must be at least 1");
    end

    // Extra pointer bit tells full from empty
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign do_wr = wr_valid_i && !full;
    assign do_rd = rd_ready_i && !empty;

    always_comb begin
        wr_ptr_nxt = do_wr ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = do_rd ? rd_ptr_r + 1'b1 : rd_ptr_r;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    // Storage needs no reset; valid gates it
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem_r[wr_ptr_r[AW-1:0]] <= wr_data_i;
        end
    end

    assign wr_ready_o = !full;
    assign rd_valid_o = !empty;
    assign rd_data_o = mem_r[rd_ptr_r[AW-1:0]];
endmodule

// ---- dv/oisp_checker.sv ----
`timescale 1ns/1ps
module oisp_checker
    import oisp_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // Watched inputs
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    input wire logic FREEZE_N_I,
    input wire logic [oisp_pkg::CH_NUM-1:0] CH_STATE_I,
    input wire logic VA_ABOVE_UVLO_I,
    input wire logic VL_ABOVE_UVLO_I,
    input wire logic [oisp_pkg::FAULT_W-1:0] FAULT_FLAGS_I,
    input wire logic OUTPUT_SELECT_BIT_I,
    input wire logic [oisp_pkg::LED_NUM-1:0] LED_ON_I,
    // Watched outputs
    input wire logic SDO_O,
    input wire logic SDO_OE_N_O,
    input wire logic [oisp_pkg::LED_NUM-1:0] LED_OUT_O,
    input wire logic [oisp_pkg::LED_NUM-1:0] LED_OE_N_O,
    input wire logic FAULT_N_O,
    input wire logic FAULT_OE_N_O,
    input wire logic READY_N_O,
    input wire logic READY_OE_N_O,
    input wire logic [oisp_pkg::CH_NUM-1:0] FROZEN_STATE_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_fault_pin: assert property (
        1 |=> FAULT_OE_N_O == ($past(FAULT_FLAGS_I) == 16'h0000) && !FAULT_N_O)
        else $error("fault pin does not follow the flags");
    a_ready_up: assert property (
        (VA_ABOVE_UVLO_I && VL_ABOVE_UVLO_I)[*4] |=> READY_OE_N_O)
        else $error("ready not given with both supplies good");
    a_ready_down: assert property (
        !(VA_ABOVE_UVLO_I && VL_ABOVE_UVLO_I) |-> ##[1:3] (!READY_OE_N_O && READY_N_O))
        else $error("ready kept with a supply low");
    a_sdo_hiz: assert property (
        CS_N_I[*5] |-> SDO_OE_N_O)
        else $error("serial output driven while deselected");
    a_sdo_open: assert property (
        $fell(CS_N_I) ##1 (!CS_N_I)[*4] |-> !SDO_OE_N_O)
        else $error("serial output not enabled after select");
    a_sdo_steady: assert property (
        (SCLK_I && !CS_N_I)[*4] |-> $stable(SDO_O))
        else $error("serial output moved in clock high phase");
    a_frz_hold: assert property (
        (!CS_N_I || !FREEZE_N_I)[*5] |-> $stable(FROZEN_STATE_O))
        else $error("frozen states moved while held");
    a_frz_track: assert property (
        (CS_N_I && FREEZE_N_I && $stable(CH_STATE_I))[*6] |-> FROZEN_STATE_O == CH_STATE_I)
        else $error("frozen states not tracking inputs");
    a_led_push: assert property (
        OUTPUT_SELECT_BIT_I |=> LED_OE_N_O == 6'h00 && LED_OUT_O == $past(LED_ON_I))
        else $error("push-pull outputs wrong");
    a_led_anode: assert property (
        !OUTPUT_SELECT_BIT_I |=> (LED_OE_N_O | 6'h38) == (~$past(LED_ON_I) | 6'h38)
            && (LED_OUT_O | LED_OE_N_O | 6'h38) == 6'h3F)
        else $error("anode outputs wrong");
    a_led_cathode: assert property (
        !OUTPUT_SELECT_BIT_I |=> (LED_OE_N_O | 6'h07) == (~$past(LED_ON_I) | 6'h07)
            && (LED_OUT_O & ~LED_OE_N_O & 6'h38) == 6'h00)
        else $error("cathode outputs wrong");
endmodule

bind oisp_top oisp_checker i_chk (.*);

// ---- dv/oisp_spi_host.sv ----
`timescale 1ns/1ps
module oisp_spi_host (
    // SPI pins toward the device
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    logic [7:0] tx [12];
    logic [7:0] rx [12];

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end

    // Device sees edges late, so capture just before the fall
    task automatic xfer(input int n);
        // Keep the select edge off the sampling clock edge
        #5;
        cs_n_o = 1'b0;
        #437;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                sdi_o = tx[i][b];
                #200 sclk_o = 1'b1;
                #199 rx[i][b] = sdo_i;
                #1 sclk_o = 1'b0;
            end
        end
        #200 cs_n_o = 1'b1;
        sdi_o = 1'b0;
        #600;
    endtask
endmodule

// ---- dv/oisp_top_tb.sv ----
`timescale 1ns/1ps
module oisp_top_tb;
    import oisp_pkg::*;
    typedef struct packed {
        logic sel;
        logic [5:0] on;
        logic [15:0] fl;
        logic [1:0] sup;
        logic [7:0] ch;
        logic [1:0] adr;
        logic crc;
        logic chn;
        logic [5:0] oe_n;
        logic [5:0] val;
        logic flt_oe_n;
        logic rdy_oe_n;
    } oisp_tb_row_s;
    logic mclk, rst, cs_n, sclk, sdi, sdo, sdo_oe_n, sdo_w, sdo_last, freeze_n, ok;
    logic crc_on, chain_on, a0, a1, va, vl, sel, rx_ready, rx_valid, rx_ovr, crc_err;
    logic fault_n, fault_oe_n, ready_n, ready_oe_n;
    logic [7:0] ch, rx_data, frozen, d;
    logic [5:0] led_on, led_out, led_oe_n;
    logic [15:0] flags;
    int num_errors, n_compared, cyc, ovr_cnt, err_cnt;
    oisp_tb_row_s rows [4];

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // No pull on the data line: released, it shows the inverse of its last bit
    assign sdo_w = sdo_oe_n ? ~sdo_last : sdo;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (sdo_oe_n === 1'b0)
            sdo_last <= sdo;
        if (rx_ovr === 1'b1)
            ovr_cnt <= ovr_cnt + 1;
        if (crc_err === 1'b1)
            err_cnt <= err_cnt + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end

    oisp_spi_host i_host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo_w));
    oisp_top i_dut (
        .MCLK_I(mclk), .SYS_RST_I(rst), .CS_N_I(cs_n), .SCLK_I(sclk), .SDI_I(sdi),
        .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .FREEZE_N_I(freeze_n), .CH_STATE_I(ch),
        .CHECK_CODE_STRAP_I(crc_on), .CHAIN_EN_STRAP_I(chain_on),
        .CHIP_ADDR_BIT0_I(a0), .CHIP_ADDR_BIT1_I(a1), .VA_ABOVE_UVLO_I(va),
        .VL_ABOVE_UVLO_I(vl), .FAULT_FLAGS_I(flags), .OUTPUT_SELECT_BIT_I(sel),
        .LED_ON_I(led_on), .LED_OUT_O(led_out), .LED_OE_N_O(led_oe_n),
        .FAULT_N_O(fault_n), .FAULT_OE_N_O(fault_oe_n), .READY_N_O(ready_n),
        .READY_OE_N_O(ready_oe_n), .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready),
        .RX_DATA_O(rx_data), .RX_OVERRUN_O(rx_ovr), .CRC_ERR_O(crc_err),
        .FROZEN_STATE_O(frozen)
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic pop(output logic got);
        got = 1'b0;
        for (int k = 0; k < 12 && !got; k++) begin
            @(posedge mclk);
            #1 got = (rx_valid === 1'b1);
        end
        d = rx_data;
        if (got) begin
            @(posedge mclk) rx_ready <= 1'b1;
            @(posedge mclk) rx_ready <= 1'b0;
        end
    endtask

    task automatic take(input logic [7:0] e);
        logic got;
        pop(got);
        chk("rx byte", {1'b1, 7'h00, e}, {got, 7'h00, d});
    endtask

    task automatic empty(input string what);
        repeat (12) @(posedge mclk);
        #1 chk(what, 16'h0000, {15'h0000, rx_valid});
    endtask

    task automatic note(input string s);
        $display("test %s finished", s);
    endtask

    function automatic logic [7:0] ref_crc(input logic [7:0] v);
        logic [7:0] c;
        c = v;
        repeat (8) c = {c[6:0], 1'b0} ^ (c[7] ? CRC_POLY : 8'h00);
        return c;
    endfunction

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        {rst, freeze_n, va, vl, a1} = 5'h1F;
        {crc_on, chain_on, a0, sel, rx_ready, sdo_last} = 6'h00;
        {ch, flags, led_on} = 30'h0;
        {num_errors, n_compared, cyc, ovr_cnt, err_cnt} = '0;
        // Last row leaves the straps as the frame tests expect them
        rows[0] = '{1'b0, 6'h3F, 16'h0000, 2'b11, 8'h3C, 2'b01, 1'b1, 1'b1,
                    6'h00, 6'h07, 1'b1, 1'b1};
        rows[1] = '{1'b0, 6'h05, 16'h8000, 2'b01, 8'hC3, 2'b11, 1'b0, 1'b1,
                    6'h3A, 6'h05, 1'b0, 1'b0};
        rows[2] = '{1'b1, 6'h2A, 16'h0001, 2'b10, 8'h5A, 2'b00, 1'b1, 1'b0,
                    6'h00, 6'h2A, 1'b0, 1'b0};
        rows[3] = '{1'b1, 6'h00, 16'h0000, 2'b11, 8'h00, 2'b10, 1'b0, 1'b0,
                    6'h00, 6'h00, 1'b1, 1'b1};
        repeat (2) @(posedge mclk);
        #1 chk("reset line", 16'h0001, {15'h0000, sdo_oe_n});
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        note("reset");
        foreach (rows[i]) begin
            @(posedge mclk);
            sel <= rows[i].sel;
            led_on <= rows[i].on;
            flags <= rows[i].fl;
            va <= rows[i].sup[1];
            vl <= rows[i].sup[0];
            ch <= rows[i].ch;
            a1 <= rows[i].adr[1];
            a0 <= rows[i].adr[0];
            crc_on <= rows[i].crc;
            chain_on <= rows[i].chn;
            repeat (6) @(posedge mclk);
            #1 chk("led enable", {10'h0, rows[i].oe_n}, {10'h0, led_oe_n});
            chk("led level", {10'h0, rows[i].val}, {10'h0, led_out & ~led_oe_n});
            chk("fault pin", {15'h0, rows[i].flt_oe_n}, {15'h0, fault_oe_n});
            chk("ready pin", {15'h0, rows[i].rdy_oe_n}, {15'h0, ready_oe_n});
            chk("row tracking", {8'h00, rows[i].ch}, {8'h00, frozen});
        end
        note("status rows");
        @(posedge mclk);
        ch <= 8'hA5;
        repeat (6) @(posedge mclk);
        #1 chk("tracking", 16'h00A5, {8'h00, frozen});
        i_host.tx[0] = 8'h91;
        i_host.tx[1] = 8'h3C;
        fork
            i_host.xfer(2);
            begin
                repeat (30) @(posedge mclk);
                ch <= 8'h0F;
                repeat (8) @(posedge mclk);
                #1 chk("held at select", 16'h00A5, {8'h00, frozen});
            end
        join
        chk("serial out", 16'h00A5, {8'h00, i_host.rx[0]});
        chk("line released", 16'h0001, {15'h0000, sdo_oe_n});
        take(8'h91);
        take(8'h3C);
        i_host.tx[0] = 8'h40;
        i_host.xfer(2);
        empty("foreign address");
        @(posedge mclk);
        a1 <= 1'b0;
        a0 <= 1'b1;
        repeat (4) @(posedge mclk);
        i_host.xfer(1);
        take(8'h40);
        note("addressed frames");
        @(posedge mclk);
        ch <= 8'h33;
        repeat (6) @(posedge mclk);
        freeze_n <= 1'b0;
        repeat (6) @(posedge mclk);
        ch <= 8'hCC;
        repeat (8) @(posedge mclk);
        #1 chk("held at strobe", 16'h0033, {8'h00, frozen});
        @(posedge mclk);
        freeze_n <= 1'b1;
        chain_on <= 1'b1;
        note("freeze strobe");
        repeat (4) @(posedge mclk);
        {i_host.tx[0], i_host.tx[1], i_host.tx[2]} = 24'h5AC300;
        i_host.xfer(3);
        chk("chain slot 1", 16'h005A, {8'h00, i_host.rx[1]});
        chk("chain slot 2", 16'h00C3, {8'h00, i_host.rx[2]});
        do pop(ok); while (ok);
        note("daisy chain");
        @(posedge mclk);
        chain_on <= 1'b0;
        crc_on <= 1'b1;
        repeat (4) @(posedge mclk);
        {i_host.tx[0], i_host.tx[1]} = {8'h40, ref_crc(8'h40)};
        {i_host.tx[2], i_host.tx[3]} = {8'h12, ref_crc(8'h12)};
        i_host.xfer(4);
        chk("check byte out", {8'h00, ref_crc(8'hCC)}, {8'h00, i_host.rx[1]});
        take(8'h40);
        take(8'h12);
        i_host.tx[1] = ~ref_crc(8'h40);
        i_host.xfer(2);
        empty("bad check byte");
        chk("check errors", 16'h0001, err_cnt[15:0]);
        note("check code");
        @(posedge mclk);
        crc_on <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int k = 1; k < 10; k++)
            i_host.tx[k] = 8'(k);
        i_host.xfer(10);
        chk("overruns", 16'h0002, ovr_cnt[15:0]);
        take(8'h40);
        for (int k = 1; k < 8; k++)
            take(8'(k));
        empty("drained");
        note("buffer full");
        wrap_up();
    end
endmodule
